/* File: rtl/ccd_current_path.sv */
`timescale 1ns/100ps
`default_nettype none
module ccd_current_path
  import ccd_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 32'(SETTLE_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic adc_valid,
  input wire logic signed [23:0] adc_cur_a,
  input wire logic signed [23:0] adc_cur_b,
  input wire logic signed [23:0] adc_cur_c,
  input wire logic signed [23:0] adc_cur_n,
  input wire logic signed [23:0] adc_volt_a,
  input wire logic signed [23:0] adc_volt_b,
  input wire logic signed [23:0] adc_volt_c,
  input wire logic signed [23:0] adc_volt_n,
  input wire logic temp_valid,
  input wire logic signed [23:0] temp_a,
  input wire logic signed [23:0] temp_b,
  input wire logic signed [23:0] temp_c,
  input wire logic signed [23:0] temp_n,
  input wire logic zx_event_level,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rd_valid,
  output logic dsp_valid,
  output logic [2:0] dsp_chan,
  output logic signed [27:0] dsp_word,
  output logic irq_n,
  output logic shared_event_pin,
  output logic phase_a_sensor_select,
  output logic phase_b_sensor_select,
  output logic phase_c_sensor_select,
  output logic neutral_sensor_select
);

  // Saturate a wide signed value to the datapath width
  function automatic logic signed [27:0] sat28(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_07ff_ffff) begin
      sat28 = 28'sh7ffffff;
    end else if (v < -64'sh0000_0000_0800_0000) begin
      sat28 = -28'sh8000000;
    end else begin
      sat28 = v[27:0];
    end
  endfunction

  // Saturate a datapath word to the 24-bit sample width
  function automatic logic signed [23:0] sat24(input logic signed [27:0] v);
    if (v > 28'sh07fffff) begin
      sat24 = 24'sh7fffff;
    end else if (v < -28'sh0800000) begin
      sat24 = -24'sh800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction

  // True when an address falls in a four-entry block
  function automatic logic in_block(input logic [15:0] a, input logic [15:0] base);
    in_block = (a[15:2] == base[15:2]);
  endfunction

  logic signed [23:0] adc_in [8];
  logic signed [23:0] temp_in [4];
  logic signed [23:0] raw_ff [8];
  logic signed [23:0] gain_ff [4];
  logic signed [23:0] ref_temp_ff [4];
  logic signed [23:0] shunt_temp_ff [4];
  logic signed [23:0] wave_ff [4];
  logic signed [DC_W-1:0] dc_ff [8];
  logic [31:0] settle_cnt_ff [4];
  logic [3:0] temp_ok_ff;
  logic [3:0] stored_ff;
  logic signed [23:0] shunt_temp_coefficient_ff;
  logic [31:0] flags_ff;
  logic [31:0] enable_ff;
  logic [15:0] settings_ff;
  logic [3:0] fe_sel_ff;
  ccd_state_e st_ff;
  logic [2:0] ch_ff;
  logic signed [27:0] acc_ff;
  logic [31:0] reg_rdata_ff;
  logic reg_rd_valid_ff;
  logic dsp_valid_ff;
  logic [2:0] dsp_chan_ff;
  logic signed [27:0] dsp_word_ff;
  logic irq_n_ff;
  logic pin_ff;
  logic [2:0] dly_ff;
  logic [9:0] low_cnt_ff;
  logic [1:0] cidx;
  logic is_cur;
  logic hpf_en;
  logic [1:0] pin_func;
  logic ready_set;
  logic signed [23:0] raw_cur;
  logic signed [23:0] gain_sel;
  logic signed [25:0] gfac;
  logic signed [49:0] gprod;
  logic signed [24:0] dt;
  logic signed [48:0] tprod;
  logic signed [27:0] tfac;
  logic signed [55:0] tcprod;
  logic signed [28:0] diff;
  logic signed [27:0] filt_out;
  logic [31:0] rd_mux;

  assign adc_in = '{adc_cur_a, adc_cur_b, adc_cur_c, adc_cur_n,
                    adc_volt_a, adc_volt_b, adc_volt_c, adc_volt_n};
  assign temp_in = '{temp_a, temp_b, temp_c, temp_n};
  assign cidx = ch_ff[1:0];
  assign is_cur = !ch_ff[2];
  assign hpf_en = settings_ff[DC_FILTER_BIT];
  assign pin_func = settings_ff[PIN_FUNC_LSB +: 2];
  assign ready_set = (st_ff == ST_DONE);

  // Shared gain, temperature and dc-removal arithmetic for the current slot
  always_comb begin
    raw_cur = raw_ff[ch_ff];
    gain_sel = is_cur ? gain_ff[cidx] : WORD_RESET;
    gfac = 26'sd8388608 + 26'(gain_sel);
    gprod = 50'(raw_cur) * 50'(gfac);
    dt = 25'(shunt_temp_ff[cidx]) - 25'(ref_temp_ff[cidx]);
    tprod = 49'(shunt_temp_coefficient_ff) * 49'(dt);
    tfac = UNITY_Q23;
    if (is_cur && stored_ff[cidx]) begin
      tfac = UNITY_Q23 - 28'(tprod >>> 23);
    end
    tcprod = 56'(acc_ff) * 56'(tfac);
    diff = 29'(acc_ff) - 29'($signed(dc_ff[ch_ff][DC_W-1:HPF_SHIFT]));
    filt_out = hpf_en ? sat28(64'(diff)) : acc_ff;
  end

  // Frame sequencer: gain, compensation and filter for each of eight slots
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ST_IDLE;
      ch_ff <= 3'h0;
      acc_ff <= 28'sh0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (adc_valid) begin
            st_ff <= ST_GAIN;
            ch_ff <= 3'h0;
          end
        end
        ST_GAIN: begin
          acc_ff <= sat28(64'(gprod) >>> 23);
          st_ff <= ST_TCOMP;
        end
        ST_TCOMP: begin
          acc_ff <= sat28(64'(tcprod) >>> 23);
          st_ff <= ST_FILT;
        end
        ST_FILT: begin
          ch_ff <= ch_ff + 3'h1;
          st_ff <= (ch_ff == 3'h7) ? ST_DONE : ST_GAIN;
        end
        ST_DONE: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // Input word capture, once per 8 kSPS frame
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      raw_ff <= '{default: WORD_RESET};
    end else if (st_ff == ST_IDLE && adc_valid) begin
      raw_ff <= adc_in;
    end
  end

  // Dc estimate per slot follows the filter output
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dc_ff <= '{default: '0};
    end else if (st_ff == ST_FILT && hpf_en) begin
      dc_ff[ch_ff] <= dc_ff[ch_ff] + DC_W'(filt_out);
    end
  end

  // Processed word stream and current waveform sample latch
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dsp_valid_ff <= 1'b0;
      dsp_chan_ff <= 3'h0;
      dsp_word_ff <= 28'sh0;
      wave_ff <= '{default: WORD_RESET};
    end else begin
      dsp_valid_ff <= (st_ff == ST_FILT);
      if (st_ff == ST_FILT) begin
        dsp_chan_ff <= ch_ff;
        dsp_word_ff <= filt_out;
        if (is_cur) begin
          wave_ff[cidx] <= sat24(filt_out);
        end
      end
    end
  end

  // Temperature settle timers and measured shunt temperatures
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt_ff <= '{default: 32'h0};
      temp_ok_ff <= 4'h0;
      stored_ff <= 4'h0;
      shunt_temp_ff <= '{default: WORD_RESET};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (fe_sel_ff[i]) begin
          settle_cnt_ff[i] <= 32'h0;
          temp_ok_ff[i] <= 1'b0;
          stored_ff[i] <= 1'b0;
        end else if (!temp_ok_ff[i]) begin
          if (settle_cnt_ff[i] == SETTLE_CYCLES - 1) begin
            temp_ok_ff[i] <= 1'b1;
          end else begin
            settle_cnt_ff[i] <= settle_cnt_ff[i] + 32'h1;
          end
        end else if (temp_valid) begin
          shunt_temp_ff[i] <= temp_in[i];
          stored_ff[i] <= 1'b1;
        end
      end
    end
  end

  // Software-written configuration registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gain_ff <= '{default: WORD_RESET};
      ref_temp_ff <= '{default: WORD_RESET};
      shunt_temp_coefficient_ff <= WORD_RESET;
      enable_ff <= ENABLE_RESET;
      settings_ff <= SETTINGS_RESET;
      fe_sel_ff <= FE_SELECT_RESET;
    end else if (reg_wr) begin
      if (in_block(reg_addr, ADDR_GAIN_BASE)) begin
        gain_ff[reg_addr[1:0]] <= reg_wdata[27:4];
      end
      if (in_block(reg_addr, ADDR_REFTEMP_BASE)) begin
        ref_temp_ff[reg_addr[1:0]] <= reg_wdata[23:0];
      end
      if (reg_addr == ADDR_SHUNT_TEMP_COEFFICIENT) begin
        shunt_temp_coefficient_ff <= reg_wdata[23:0];
      end
      if (reg_addr == ADDR_ENABLE0) begin
        enable_ff <= reg_wdata;
      end
      if (reg_addr == ADDR_SETTINGS) begin
        settings_ff <= reg_wdata[15:0];
      end
      if (reg_addr == ADDR_FE_SELECT) begin
        fe_sel_ff <= reg_wdata[3:0];
      end
    end
  end

  // Sample-ready flag: write one to clear, a new frame wins over the clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= FLAGS_RESET;
    end else if (ready_set) begin
      flags_ff[SAMPLE_READY_BIT] <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_FLAGS0 && reg_wdata[SAMPLE_READY_BIT]) begin
      flags_ff[SAMPLE_READY_BIT] <= 1'b0;
    end
  end

  // Active-low interrupt from enabled flags
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= !(flags_ff[SAMPLE_READY_BIT] && enable_ff[SAMPLE_READY_BIT]);
    end
  end

  // Shared event pin: delayed 10 us low pulse, or zero-crossing level
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_ff <= 1'b1;
      dly_ff <= 3'h0;
      low_cnt_ff <= 10'h0;
    end else if (pin_func != PIN_FUNC_READY) begin
      pin_ff <= zx_event_level;
      dly_ff <= 3'h0;
      low_cnt_ff <= 10'h0;
    end else if (ready_set) begin
      dly_ff <= 3'(PIN_DELAY_CYC);
    end else if (dly_ff != 3'h0) begin
      dly_ff <= dly_ff - 3'h1;
      if (dly_ff == 3'h1) begin
        pin_ff <= 1'b0;
        low_cnt_ff <= 10'(PIN_LOW_CYC);
      end
    end else if (low_cnt_ff != 10'h0) begin
      low_cnt_ff <= low_cnt_ff - 10'h1;
      if (low_cnt_ff == 10'h1) begin
        pin_ff <= 1'b1;
      end
    end
  end

  // Read formatting for each register kind
  always_comb begin
    rd_mux = 32'h0;
    if (in_block(reg_addr, ADDR_GAIN_BASE)) begin
      rd_mux = {{4{gain_ff[reg_addr[1:0]][23]}}, gain_ff[reg_addr[1:0]], 4'h0};
    end else if (in_block(reg_addr, ADDR_REFTEMP_BASE)) begin
      rd_mux = 32'(ref_temp_ff[reg_addr[1:0]]);
    end else if (in_block(reg_addr, ADDR_SHUNT_BASE)) begin
      rd_mux = {8'h0, shunt_temp_ff[reg_addr[1:0]]};
    end else if (in_block(reg_addr, ADDR_SAMPLE_BASE)) begin
      rd_mux = 32'(wave_ff[reg_addr[1:0]]);
    end else if (reg_addr == ADDR_SHUNT_TEMP_COEFFICIENT) begin
      rd_mux = 32'(shunt_temp_coefficient_ff);
    end else if (reg_addr == ADDR_FLAGS0) begin
      rd_mux = flags_ff;
    end else if (reg_addr == ADDR_ENABLE0) begin
      rd_mux = enable_ff;
    end else if (reg_addr == ADDR_SETTINGS) begin
      rd_mux = {16'h0, settings_ff};
    end else if (reg_addr == ADDR_FE_SELECT) begin
      rd_mux = {28'h0, fe_sel_ff};
    end
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= 32'h0;
      reg_rd_valid_ff <= 1'b0;
    end else begin
      reg_rd_valid_ff <= reg_rd;
      if (reg_rd) begin
        reg_rdata_ff <= rd_mux;
      end
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign reg_rd_valid = reg_rd_valid_ff;
  assign dsp_valid = dsp_valid_ff;
  assign dsp_chan = dsp_chan_ff;
  assign dsp_word = dsp_word_ff;
  assign irq_n = irq_n_ff;
  assign shared_event_pin = pin_ff;
  assign phase_a_sensor_select = fe_sel_ff[0];
  assign phase_b_sensor_select = fe_sel_ff[1];
  assign phase_c_sensor_select = fe_sel_ff[2];
  assign neutral_sensor_select = fe_sel_ff[3];

  // Helpers watched only by the checks below
  logic [9:0] low_run_ff;
  logic [15:0] rd_addr_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_run_ff <= 10'h0;
      rd_addr_ff <= 16'h0;
    end else begin
      low_run_ff <= pin_ff ? 10'h0 : low_run_ff + 10'h1;
      if (reg_rd) begin
        rd_addr_ff <= reg_addr;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_gain_half;
    (st_ff == ST_GAIN && is_cur && gain_ff[cidx] == 24'sh400000)
      |=> acc_ff == 28'((30'($past(raw_cur)) * 30'sd3) >>> 1);
  endproperty
  a_gain_half: assert property (p_gain_half) else $error("gain of one half not applied");
  property p_frame_len;
    (st_ff == ST_IDLE && adc_valid) |-> ##25 (st_ff == ST_DONE);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not finished in 25 cycles");
  property p_flag_set;
    (st_ff == ST_DONE) |=> flags_ff[SAMPLE_READY_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("sample-ready flag not set");
  property p_irq;
    (flags_ff[SAMPLE_READY_BIT] && enable_ff[SAMPLE_READY_BIT]) |=> !irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag did not raise interrupt");
  property p_pin_delay;
    (ready_set && pin_func == PIN_FUNC_READY && pin_ff && low_cnt_ff == 10'h0)
      |-> ##1 pin_ff [*3] ##1 !pin_ff;
  endproperty
  a_pin_delay: assert property (p_pin_delay) else $error("pin low edge mistimed");
  property p_pin_width;
    ($rose(pin_ff) && pin_func == PIN_FUNC_READY && $past(pin_func) == PIN_FUNC_READY)
      |-> low_run_ff == 10'd500;
  endproperty
  a_pin_width: assert property (p_pin_width) else $error("pin low time not 10 us");
  property p_sample_sext;
    (reg_rd_valid_ff && in_block(rd_addr_ff, ADDR_SAMPLE_BASE))
      |-> reg_rdata_ff[31:24] == {8{reg_rdata_ff[23]}};
  endproperty
  a_sample_sext: assert property (p_sample_sext) else $error("sample not sign extended");
  property p_gain_fmt;
    (reg_rd_valid_ff && in_block(rd_addr_ff, ADDR_GAIN_BASE))
      |-> reg_rdata_ff[3:0] == 4'h0 && reg_rdata_ff[31:27] == {5{reg_rdata_ff[27]}};
  endproperty
  a_gain_fmt: assert property (p_gain_fmt) else $error("gain read format wrong");
  property p_bypass;
    (st_ff == ST_FILT && !hpf_en) |=> dsp_word == $past(acc_ff);
  endproperty
  a_bypass: assert property (p_bypass) else $error("filter not bypassed");
  property p_no_comp;
    (st_ff == ST_TCOMP && !stored_ff[cidx] && acc_ff > -28'sh4000000 && acc_ff < 28'sh4000000)
      |=> acc_ff == $past(acc_ff);
  endproperty
  a_no_comp: assert property (p_no_comp) else $error("compensation before settle");
  property p_temp_gate;
    $changed(shunt_temp_ff[0]) |-> $past(temp_ok_ff[0]);
  endproperty
  a_temp_gate: assert property (p_temp_gate) else $error("temperature stored early");
  property p_select;
    (reg_wr && reg_addr == ADDR_FE_SELECT && !reg_wdata[0]) |=> !phase_a_sensor_select;
  endproperty
  a_select: assert property (p_select) else $error("select output not driven low");
  c_frame: cover property (st_ff == ST_DONE && hpf_en);
  c_pin_pulse: cover property ($rose(pin_ff) && pin_func == PIN_FUNC_READY);
  c_temp_stored: cover property ($rose(stored_ff[0]));
  c_flag_clear: cover property ($fell(flags_ff[SAMPLE_READY_BIT]));

endmodule
`default_nettype wire

/* File: rtl/ccd_pkg.sv */
// How it works
// - Each current channel yields one signed 24-bit word per channel at 8 kSPS.
// - Full-scale current input maps to nominal codes near plus or minus 5,320,000.
// - Current word is multiplied by one plus signed gain over 2^23.
// - Gained current feeds every downstream calculation and the stored samples.
// - Gain registers read as sign-extended 28 bits followed by four zeros.
// - One signed 24-bit temperature coefficient is shared by all four channels.
// - After gain, multiply by one minus coefficient times temperature difference.
// - Each channel has a signed 24-bit reference temperature register.
// - Each channel has a measured shunt temperature register fed by its sensor.
// - Temperatures stored 1.024 s after select goes low; compensation then runs.
// - Settings bit 4 enables all dc-removal filters, default on.
// - Current samples latched after the filter into four registers at 8 kSPS.
// - Flag bit 17 sets when new current samples are ready.
// - Enable bit 17 lets the ready flag assert the interrupt.
// - Pin function 00: pin goes low about 70 ns after flag, 10 us low.
// - Sample registers read as 32 bits with bits 31 to 24 copying bit 23.
// - Voltage channels also give signed 24-bit words at 8 kSPS.
// - Select register bits 3 to 0 drive the four select outputs, default high.
// - Select held low 1.024 s before first temperature store, then 8 kSPS refresh.
package ccd_pkg;
  localparam int ADC_W = 24;
  localparam int DP_W = 28;
  localparam int HPF_SHIFT = 10;
  localparam int DC_W = DP_W + HPF_SHIFT;
  // Register addresses
  localparam logic [15:0] ADDR_FLAGS0 = 16'he502;
  localparam logic [15:0] ADDR_ENABLE0 = 16'he50a;
  localparam logic [15:0] ADDR_SETTINGS = 16'he618;
  localparam logic [15:0] ADDR_FE_SELECT = 16'he708;
  localparam logic [15:0] ADDR_GAIN_BASE = 16'h4380;
  localparam logic [15:0] ADDR_SHUNT_TEMP_COEFFICIENT = 16'h4388;
  localparam logic [15:0] ADDR_REFTEMP_BASE = 16'h4390;
  localparam logic [15:0] ADDR_SHUNT_BASE = 16'h4398;
  localparam logic [15:0] ADDR_SAMPLE_BASE = 16'h43a0;
  // Field positions and reset values
  localparam int SAMPLE_READY_BIT = 17;
  localparam int DC_FILTER_BIT = 4;
  localparam int PIN_FUNC_LSB = 0;
  localparam logic [1:0] PIN_FUNC_READY = 2'h0;
  localparam logic [15:0] SETTINGS_RESET = 16'h0010;
  localparam logic [3:0] FE_SELECT_RESET = 4'hf;
  localparam logic [31:0] FLAGS_RESET = 32'h0;
  localparam logic [31:0] ENABLE_RESET = 32'h0;
  localparam logic signed [23:0] WORD_RESET = 24'sh000000;
  localparam logic signed [27:0] UNITY_Q23 = 28'sh0800000;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned PIN_DELAY_NS = 70;
  localparam int unsigned PIN_DELAY_CYC = PIN_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned PIN_LOW_NS = 10000;
  localparam int unsigned PIN_LOW_CYC = PIN_LOW_NS / CLK_PERIOD_NS;
  localparam longint unsigned SETTLE_US = 1024000;
  localparam longint unsigned SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GAIN = 3'b001,
    ST_TCOMP = 3'b010,
    ST_FILT = 3'b011,
    ST_DONE = 3'b100
  } ccd_state_e;
endpackage

/* File: dv/ccd_fe_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ccd_fe_model (
  input wire logic fire,
  input wire logic signed [23:0] word_in,
  input wire logic signed [23:0] temp_in,
  input wire logic [3:0] slot_sel,
  output logic adc_valid,
  output logic temp_valid,
  output logic signed [23:0] cur_word,
  output logic signed [23:0] temp_word
);
  // Strobes follow the request; words toggle outside the strobe so stale data never matches
  assign adc_valid = fire;
  // Temperature strobe comes with the sample strobe only while the device drives every select low
  assign temp_valid = fire && (slot_sel == 4'h0);
  assign cur_word = fire ? word_in : ~word_in;
  assign temp_word = fire ? temp_in : ~temp_in;
endmodule
`default_nettype wire

/* File: dv/current_channel_dsp_path_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module current_channel_dsp_path_bench;
  import ccd_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic fire = 1'b0;
  logic zx = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic signed [23:0] word_in = 24'sh0;
  logic adc_valid, temp_valid, reg_rd_valid, irq_n, pin;
  logic signed [23:0] cur_word, temp_word;
  logic [31:0] reg_rdata, got;
  logic [3:0] sel;
  logic dsp_valid;
  logic [2:0] dsp_chan;
  logic signed [27:0] dsp_word;
  logic signed [27:0] dsp1 = 28'sh0;
  int dsp_cnt = 0;
  logic [23:0] gains [4] = '{24'h400000, 24'h000000, 24'hc00000, 24'h200000};
  logic signed [23:0] refs [4] = '{24'sh200000, 24'sh0, -24'sh200000, 24'sh0};
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32'h24d0;

  // Clock and hang guard
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      complete_run();
    end
  end

  ccd_fe_model fe (.fire(fire), .word_in(word_in), .temp_in(24'sh400000), .slot_sel(sel),
    .adc_valid(adc_valid), .temp_valid(temp_valid), .cur_word(cur_word), .temp_word(temp_word));

  ccd_current_path #(.SETTLE_CYCLES(20)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .adc_valid(adc_valid),
    .adc_cur_a(cur_word), .adc_cur_b(cur_word), .adc_cur_c(cur_word), .adc_cur_n(cur_word),
    .adc_volt_a(~cur_word), .adc_volt_b(~cur_word), .adc_volt_c(~cur_word),
    .adc_volt_n(~cur_word), .temp_valid(temp_valid), .temp_a(temp_word), .temp_b(temp_word),
    .temp_c(temp_word), .temp_n(temp_word), .zx_event_level(zx), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .dsp_valid(dsp_valid), .dsp_chan(dsp_chan),
    .dsp_word(dsp_word), .irq_n(irq_n),
    .shared_event_pin(pin), .phase_a_sensor_select(sel[0]), .phase_b_sensor_select(sel[1]),
    .phase_c_sensor_select(sel[2]), .neutral_sensor_select(sel[3]));

  // Processed word stream watched at the falling edge, where it stands settled
  always @(negedge clk_sys) begin
    if (dsp_valid === 1'b1) begin
      dsp_cnt++;
      if (dsp_chan === 3'h1) begin
        dsp1 = dsp_word;
      end
    end
  end

  // Expected sample: gain, optional temperature factor, saturation, sign extension
  function automatic logic [31:0] exp_smp(input logic signed [23:0] x, input int i, input bit on);
    longint p;
    p = (longint'(x) * (64'sh800000 + longint'($signed(gains[i])))) >>> 23;
    if (on) begin
      p = (p * (64'sh800000 - ((64'sh400000 * (64'sh400000 - longint'(refs[i]))) >>> 23))) >>> 23;
    end
    if (p > 64'sh7fffff) p = 64'sh7fffff;
    if (p < -64'sh800000) p = -64'sh800000;
    return 32'(p);
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  // Read strobe for one cycle, data taken with the valid pulse
  task automatic rd(input logic [15:0] a);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk({31'h0, reg_rd_valid}, 32'h1);
    got = reg_rdata;
  endtask

  // One frame: pin delay and width, flag, interrupt, then clear
  task automatic frame(input logic signed [23:0] x);
    int n;
    int lo;
    int d;
    n = 0;
    lo = 0;
    d = dsp_cnt;
    @(negedge clk_sys);
    word_in = x;
    fire = 1'b1;
    @(negedge clk_sys);
    fire = 1'b0;
    while (pin === 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(32'(n), 32'd25 + PIN_DELAY_CYC);
    while (pin === 1'b0 && lo < 600) begin
      @(posedge clk_sys);
      #1;
      lo++;
    end
    chk(32'(lo), PIN_LOW_CYC);
    chk(32'(dsp_cnt - d), 32'd8);
    rd(ADDR_FLAGS0);
    chk({31'h0, got[SAMPLE_READY_BIT]}, 32'h1);
    chk({31'h0, irq_n}, 32'h0);
    wr(ADDR_FLAGS0, 32'h20000);
    @(posedge clk_sys);
    #1;
    chk({31'h0, irq_n}, 32'h1);
  endtask

  task automatic smp(input logic signed [23:0] x, input bit on);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_SAMPLE_BASE + 16'(i));
      chk(got, exp_smp(x, i, on));
    end
    chk(32'(dsp1), exp_smp(x, 1, on));
  endtask

  task automatic complete_run();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic signed [23:0] x;
    logic signed [23:0] xs [4];
    xs = '{24'sh7ffff0, -24'sh800000, 24'sh000010, -24'sh000010};
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    rd(ADDR_SETTINGS);
    chk(got, {16'h0, SETTINGS_RESET});
    chk({28'h0, sel}, 32'hf);
    chk({31'h0, pin}, 32'h1);
    wr(ADDR_SETTINGS, 32'h0);
    wr(ADDR_ENABLE0, 32'h20000);
    wr(ADDR_SHUNT_TEMP_COEFFICIENT, 32'h400000);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_GAIN_BASE + 16'(i), {{4{gains[i][23]}}, gains[i], 4'h0});
      wr(ADDR_REFTEMP_BASE + 16'(i), {8'h0, refs[i]});
      rd(ADDR_GAIN_BASE + 16'(i));
      chk(got, {{4{gains[i][23]}}, gains[i], 4'h0});
    end
    for (int k = 0; k < 8; k++) begin
      x = (k < 4) ? xs[k] : 24'($random(seed)) & 24'hfffff0;
      frame(x);
      smp(x, 1'b0);
    end
    wr(ADDR_FE_SELECT, 32'h0);
    @(negedge clk_sys);
    chk({28'h0, sel}, 32'h0);
    frame(x);
    rd(ADDR_SHUNT_BASE);
    chk(got, 32'h0);
    frame(x);
    rd(ADDR_SHUNT_BASE + 16'h3);
    chk(got, 32'h00400000);
    x = 24'($random(seed)) & 24'hfffff0;
    frame(x);
    smp(x, 1'b1);
    wr(ADDR_FE_SELECT, 32'hf);
    frame(x);
    smp(x, 1'b0);
    wr(ADDR_SETTINGS, 32'h10);
    frame(24'sh100000);
    frame(24'sh100000);
    rd(ADDR_SAMPLE_BASE);
    chk({31'h0, $signed(got) < $signed(exp_smp(24'sh100000, 0, 1'b0))}, 32'h1);
    wr(ADDR_SETTINGS, 32'h11);
    @(negedge clk_sys);
    zx = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({31'h0, pin}, 32'h1);
    zx = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({31'h0, pin}, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
